// ==== rtcpc_pkg.sv ====
// Purpose: Shared constants and types for the RTC prescaler/counter core
// Assumes: 16-bit half registers on a zero-wait peripheral bus
// Notes: Offsets are byte addresses, one aligned word per register
package rtcpc_pkg;
  localparam int PRL_W = 20;
  localparam int CNT_W = 32;
  localparam int HALF_W = 16;
  localparam int ADDR_W = 8;
  localparam int PRLH_FIELD_W = 4;
  localparam int COMMIT_CYCLES = 3;

  localparam logic [ADDR_W-1:0] OFF_PRLH = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_PRLL = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_DIVH = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_DIVL = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_CNTH = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_CNTL = 8'h1c;
  localparam logic [ADDR_W-1:0] OFF_ALRH = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_ALRL = 8'h24;

  localparam logic [HALF_W-1:0] PRLH_RST = 16'h0000;
  localparam logic [HALF_W-1:0] PRLL_RST = 16'h8000;
  localparam logic [HALF_W-1:0] DIVH_RST = 16'h0000;
  localparam logic [HALF_W-1:0] DIVL_RST = 16'h8000;
  localparam logic [HALF_W-1:0] CNT_RST = 16'h0000;
  localparam logic [HALF_W-1:0] ALR_RST = 16'hffff;
  localparam logic [HALF_W-1:0] ZERO_HALF = 16'h0000;

  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [HALF_W-1:0] wdata;
  } rtcpc_bus_req_t;

  typedef enum {
    REG_NONE, REG_PRLH, REG_PRLL, REG_DIVH, REG_DIVL,
    REG_CNTH, REG_CNTL, REG_ALRH, REG_ALRL
  } rtcpc_reg_t;

  function automatic rtcpc_reg_t rtcpc_decode(logic [ADDR_W-1:0] a);
    rtcpc_reg_t r;
    r = REG_NONE;
    unique case (a)
      OFF_PRLH: r = REG_PRLH;
      OFF_PRLL: r = REG_PRLL;
      OFF_DIVH: r = REG_DIVH;
      OFF_DIVL: r = REG_DIVL;
      OFF_CNTH: r = REG_CNTH;
      OFF_CNTL: r = REG_CNTL;
      OFF_ALRH: r = REG_ALRH;
      OFF_ALRL: r = REG_ALRL;
      default: r = REG_NONE;
    endcase
    return r;
  endfunction
endpackage

// ==== rtcpc_sub.sv ====
// Purpose: Prescaler down-counter and write-commit sequencer
// Assumes: One kernel clock cycle per clk edge
// Notes: Both modules are leaves of rtcpc_core
`timescale 1ns/10ps
module rtcpc_prescaler import rtcpc_pkg::*; #(
  parameter int W = PRL_W
) (
  input wire logic clk, // Kernel clock
  input wire logic rst, // Sync reset, high
  input wire logic [W-1:0] reload_value, // Period minus one
  input wire logic load, // Force reload now
  output logic [W-1:0] remain_reg, // Live remainder
  output logic wrap // Last cycle of a period
);
  initial begin
    if (W < 2 || W > 2*HALF_W) $error("rtcpc_prescaler: bad W");
  end

  assign wrap = (remain_reg == '0) && !load;

  always_ff @(posedge clk) begin
    if (rst) begin
      remain_reg <= W'({DIVH_RST, DIVL_RST});
    end else if (load || remain_reg == '0) begin
      remain_reg <= reload_value;
    end else begin
      remain_reg <= remain_reg - W'(1);
    end
  end
endmodule // rtcpc_prescaler

module rtcpc_commit import rtcpc_pkg::*; #(
  parameter int CYCLES = COMMIT_CYCLES
) (
  input wire logic clk, // Kernel clock
  input wire logic rst, // Sync reset, high
  input wire logic config_mode, // Configuration mode level
  input wire logic queued, // A write was queued
  output logic idle_reg, // No write in progress
  output logic apply_reg // One-cycle commit pulse
);
  typedef enum {ST_IDLE, ST_BUSY} rtcpc_cstate_t;
  rtcpc_cstate_t state_reg;
  logic cfg_prev_reg;
  logic pending_reg;
  logic [3:0] count_reg;
  logic start;

  initial begin
    if (CYCLES < 1 || CYCLES > 15) $error("rtcpc_commit: bad CYCLES");
  end

  assign start = cfg_prev_reg && !config_mode && (pending_reg || queued);

  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_prev_reg <= 1'b0;
    end else begin
      cfg_prev_reg <= config_mode;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || start) begin
      pending_reg <= 1'b0;
    end else if (queued) begin
      pending_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      count_reg <= '0;
      idle_reg <= 1'b1;
      apply_reg <= 1'b0;
    end else begin
      apply_reg <= 1'b0;
      unique case (state_reg)
        ST_IDLE: begin
          if (start) begin
            state_reg <= ST_BUSY;
            count_reg <= 4'(CYCLES - 1);
            idle_reg <= 1'b0;
          end
        end
        ST_BUSY: begin
          if (count_reg == '0) begin
            state_reg <= ST_IDLE;
            apply_reg <= 1'b1;
            idle_reg <= 1'b1;
          end else begin
            count_reg <= count_reg - 4'(1);
          end
        end
      endcase
    end
  end
endmodule // rtcpc_commit

// ==== rtcpc_core.sv ====
// Purpose: RTC prescaler, 32-bit time counter and alarm compare
// Assumes: clk is the kernel clock; bus is zero-wait, 16-bit halves
// Notes: Writes queue in shadows and commit after configuration mode
`timescale 1ns/10ps
module rtcpc_core import rtcpc_pkg::*; #(
  parameter int PW = PRL_W,
  parameter int CW = CNT_W
) (
  input wire logic clk, // Kernel and bus clock
  input wire logic rst, // Sync reset, high
  input wire rtcpc_bus_req_t bus_req, // Bus request
  output logic [HALF_W-1:0] prdata_reg, // Read data
  output logic pready_reg, // Access phase done
  output logic pslverr_reg, // Always zero
  input wire logic config_mode_bit, // Configuration mode
  output logic write_idle_flag, // No write in progress
  output logic time_base_tick, // One pulse per period
  output logic alarm_flag, // Alarm event pulse
  output logic alarm_irq, // Alarm request pulse
  output logic overflow_flag // Overflow event pulse
);
  initial begin
    if (PW != PRL_W || CW != CNT_W) $error("rtcpc_core: widths fixed");
  end

  logic [PW-1:0] prl_reg;
  logic [CW-1:0] count_reg;
  logic [CW-1:0] alarm_reg;
  logic [PW-1:0] prl_sh_reg;
  logic [CW-1:0] cnt_sh_reg;
  logic [CW-1:0] alr_sh_reg;
  logic [5:0] pend_reg;
  logic [PW-1:0] remain;
  logic wrap;
  logic idle;
  logic apply;
  logic setup;
  logic wr_acc;
  logic queue;
  logic reload_now;
  rtcpc_reg_t rsel;
  rtcpc_reg_t wsel;

  assign rsel = rtcpc_decode(bus_req.addr);
  assign wsel = rsel;
  assign setup = bus_req.sel && !bus_req.enable;
  assign wr_acc = bus_req.sel && bus_req.enable && bus_req.write;
  // write gate: flag and sequencer idle, config mode set
  // Flag lags idle a cycle; both needed so no write meets the commit
  assign queue = wr_acc && idle && write_idle_flag && config_mode_bit &&
                 (wsel inside {REG_PRLH, REG_PRLL, REG_CNTH, REG_CNTL,
                               REG_ALRH, REG_ALRL});
  // reload on reload or counter change
  assign reload_now = apply && (pend_reg[1:0] != '0 || pend_reg[3:2] != '0);

  rtcpc_commit #(.CYCLES(COMMIT_CYCLES)) u_commit (
    .clk(clk),
    .rst(rst),
    .config_mode(config_mode_bit),
    .queued(queue),
    .idle_reg(idle),
    .apply_reg(apply)
  );

  rtcpc_prescaler #(.W(PW)) u_presc (
    .clk(clk),
    .rst(rst),
    .reload_value(apply ? {pend_reg[0] ? prl_sh_reg[PW-1:HALF_W] :
                           prl_reg[PW-1:HALF_W],
                           pend_reg[1] ? prl_sh_reg[HALF_W-1:0] :
                           prl_reg[HALF_W-1:0]} : prl_reg),
    .load(reload_now),
    .remain_reg(remain),
    .wrap(wrap)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      prl_sh_reg <= '0;
      cnt_sh_reg <= '0;
      alr_sh_reg <= '0;
      pend_reg <= '0;
    end else if (apply) begin
      pend_reg <= '0;
    end else if (queue) begin
      unique case (wsel)
        REG_PRLH: begin
          prl_sh_reg[PW-1:HALF_W] <= bus_req.wdata[PRLH_FIELD_W-1:0];
          pend_reg[0] <= 1'b1;
        end
        REG_PRLL: begin
          prl_sh_reg[HALF_W-1:0] <= bus_req.wdata;
          pend_reg[1] <= 1'b1;
        end
        REG_CNTH: begin
          cnt_sh_reg[CW-1:HALF_W] <= bus_req.wdata;
          pend_reg[2] <= 1'b1;
        end
        REG_CNTL: begin
          cnt_sh_reg[HALF_W-1:0] <= bus_req.wdata;
          pend_reg[3] <= 1'b1;
        end
        REG_ALRH: begin
          alr_sh_reg[CW-1:HALF_W] <= bus_req.wdata;
          pend_reg[4] <= 1'b1;
        end
        REG_ALRL: begin
          alr_sh_reg[HALF_W-1:0] <= bus_req.wdata;
          pend_reg[5] <= 1'b1;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prl_reg <= PW'({PRLH_RST, PRLL_RST});
    end else if (apply) begin
      if (pend_reg[0]) begin
        prl_reg[PW-1:HALF_W] <= prl_sh_reg[PW-1:HALF_W];
      end
      if (pend_reg[1]) begin
        prl_reg[HALF_W-1:0] <= prl_sh_reg[HALF_W-1:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      alarm_reg <= {ALR_RST, ALR_RST};
    end else if (apply) begin
      if (pend_reg[4]) begin
        alarm_reg[CW-1:HALF_W] <= alr_sh_reg[CW-1:HALF_W];
      end
      if (pend_reg[5]) begin
        alarm_reg[HALF_W-1:0] <= alr_sh_reg[HALF_W-1:0];
      end
    end
  end

  // advance per tick; direct half load wins
  always_ff @(posedge clk) begin
    if (rst) begin
      count_reg <= {CNT_RST, CNT_RST};
    end else if (apply && pend_reg[3:2] != '0) begin
      if (pend_reg[2]) begin
        count_reg[CW-1:HALF_W] <= cnt_sh_reg[CW-1:HALF_W];
      end
      if (pend_reg[3]) begin
        count_reg[HALF_W-1:0] <= cnt_sh_reg[HALF_W-1:0];
      end
    end else if (wrap) begin
      count_reg <= count_reg + CW'(1);
    end
  end

  // event pulses registered, high on the cycle after the last cycle of a period
  always_ff @(posedge clk) begin
    if (rst) begin
      time_base_tick <= 1'b0;
      alarm_flag <= 1'b0;
      alarm_irq <= 1'b0;
      overflow_flag <= 1'b0;
      write_idle_flag <= 1'b1;
    end else begin
      time_base_tick <= wrap;
      alarm_flag <= wrap && count_reg == alarm_reg;
      alarm_irq <= wrap && count_reg == alarm_reg;
      overflow_flag <= wrap && count_reg == '1;
      write_idle_flag <= idle && !(apply && !idle);
    end
  end

  // read data captured in setup phase
  always_ff @(posedge clk) begin
    if (rst) begin
      prdata_reg <= ZERO_HALF;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= setup;
      pslverr_reg <= 1'b0;
      if (setup && !bus_req.write) begin
        unique case (rsel)
          REG_DIVH: prdata_reg <= HALF_W'(remain[PW-1:HALF_W]);
          REG_DIVL: prdata_reg <= remain[HALF_W-1:0];
          REG_CNTH: prdata_reg <= count_reg[CW-1:HALF_W];
          REG_CNTL: prdata_reg <= count_reg[HALF_W-1:0];
          default: prdata_reg <= ZERO_HALF;
        endcase
      end else begin
        prdata_reg <= ZERO_HALF;
      end
    end
  end

  property p_refuse_busy;
    @(posedge clk) disable iff (rst)
    wr_acc && !write_idle_flag |=> $stable(pend_reg) || pend_reg == '0;
  endproperty
  a_refuse_busy: assert property (p_refuse_busy)
    else $error("write taken while busy");

  property p_prlh_reads_zero;
    @(posedge clk) disable iff (rst)
    setup && !bus_req.write && rsel == REG_PRLH |=> prdata_reg == '0;
  endproperty
  a_prlh_reads_zero: assert property (p_prlh_reads_zero)
    else $error("reload high read not zero");

  property p_period_reload;
    @(posedge clk) disable iff (rst)
    wrap && !apply |=> remain == $past(prl_reg);
  endproperty
  a_period_reload: assert property (p_period_reload)
    else $error("prescaler not reloaded at wrap");

  property p_commit_reload;
    @(posedge clk) disable iff (rst)
    apply && pend_reg[1:0] == 2'b11 |=> remain == $past(prl_sh_reg);
  endproperty
  a_commit_reload: assert property (p_commit_reload)
    else $error("prescaler not reloaded on commit");

  property p_count_step;
    @(posedge clk) disable iff (rst)
    wrap && !apply |=> count_reg == $past(count_reg) + CW'(1);
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("counter did not advance on tick");

  property p_cnt_load;
    @(posedge clk) disable iff (rst)
    apply && pend_reg[3:2] == 2'b11 |=> count_reg == $past(cnt_sh_reg);
  endproperty
  a_cnt_load: assert property (p_cnt_load)
    else $error("counter not loaded on commit");

  property p_cnt_read;
    @(posedge clk) disable iff (rst)
    setup && !bus_req.write && rsel == REG_CNTL
      |=> prdata_reg == $past(count_reg[HALF_W-1:0]);
  endproperty
  a_cnt_read: assert property (p_cnt_read)
    else $error("counter low read mismatch");

  property p_alarm;
    @(posedge clk) disable iff (rst)
    wrap && count_reg == alarm_reg |=> alarm_flag && alarm_irq;
  endproperty
  a_alarm: assert property (p_alarm)
    else $error("alarm not raised at match");

  property p_busy_window;
    @(posedge clk) disable iff (rst)
    $fell(idle) |-> !apply [*3] ##1 apply;
  endproperty
  a_busy_window: assert property (p_busy_window)
    else $error("commit not three cycles after start");

  property p_idle_low;
    @(posedge clk) disable iff (rst)
    $fell(idle) |=> !write_idle_flag [*3];
  endproperty
  a_idle_low: assert property (p_idle_low)
    else $error("write idle high during commit");

  property p_overflow;
    @(posedge clk) disable iff (rst)
    overflow_flag |-> $past(count_reg) == '1 && count_reg == '0;
  endproperty
  a_overflow: assert property (p_overflow)
    else $error("overflow without wrap to zero");
endmodule // rtcpc_core

// ==== rtcpc_host.sv ====
// Purpose: Host model issuing register cycles to the RTC core
// Assumes: Setup/access bus, one request at a time, no wait states
// Notes: Released address and data lines show inverted values
`timescale 1ns/10ps
module rtcpc_host import rtcpc_pkg::*; (
  input wire logic clk, // Kernel clock
  input wire logic [HALF_W-1:0] prdata_reg, // Read data
  input wire logic pready_reg, // Access done
  input wire logic write_idle_flag, // No write in progress
  output rtcpc_bus_req_t bus_req, // Bus request
  output logic config_mode_bit // Configuration mode
);
  localparam int DLY = 1;

  initial begin
    bus_req = '0;
    config_mode_bit = 1'b0;
  end

  // Idle cycle first, so no line is driven twice in one step
  task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a,
      input logic [HALF_W-1:0] d, output logic [HALF_W-1:0] q);
    int n;
    n = 0;
    @(posedge clk);
    #DLY bus_req.sel = 1'b1;
    bus_req.enable = 1'b0;
    bus_req.write = wr;
    bus_req.addr = a;
    bus_req.wdata = d;
    @(posedge clk);
    #DLY bus_req.enable = 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready_reg !== 1'b1 && n < 8);
    q = prdata_reg;
    #DLY bus_req.sel = 1'b0;
    bus_req.enable = 1'b0;
    bus_req.addr = ~a;
    bus_req.wdata = ~d;
  endtask

  task automatic cfg_enter();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (write_idle_flag !== 1'b1 && n < 64);
    #DLY config_mode_bit = 1'b1;
  endtask

  // Raw config level change, no polling
  task automatic cfg_set(input logic v);
    @(posedge clk);
    #DLY config_mode_bit = v;
  endtask

  // clear to commit, wait for completion
  task automatic cfg_leave(output int busy);
    int n;
    n = 0;
    @(posedge clk);
    #DLY config_mode_bit = 1'b0;
    do begin
      @(posedge clk);
      n++;
    end while (write_idle_flag !== 1'b0 && n < 8);
    do begin
      @(posedge clk);
      n++;
    end while (write_idle_flag !== 1'b1 && n < 32);
    busy = n;
  endtask
endmodule // rtcpc_host

// ==== test_rtc_prescaler_counter_alarm.sv ====
// Purpose: Self-checking bench for the RTC prescaler/counter core
// Assumes: 25 MHz clock, host model drives the register bus
// Notes: Reload kept small so ticks come every few cycles
`timescale 1ns/10ps
module test_rtc_prescaler_counter_alarm import rtcpc_pkg::*;;
  typedef struct packed {
    logic [ADDR_W-1:0] a;
    logic [HALF_W-1:0] e;
  } rtcpc_rrow_t;
  typedef struct packed {
    logic [HALF_W-1:0] prll;
    logic [7:0] per;
  } rtcpc_prow_t;

  logic clk, rst, pready_reg, pslverr_reg, config_mode_bit;
  logic write_idle_flag, time_base_tick, alarm_flag, alarm_irq;
  logic overflow_flag;
  rtcpc_bus_req_t bus_req;
  logic [HALF_W-1:0] prdata_reg, q, q2;
  int miscompares, cmp_count, cycles, n, busy;
  rtcpc_rrow_t rrow [8] = '{
    '{OFF_PRLH, ZERO_HALF}, '{OFF_PRLL, ZERO_HALF},
    '{OFF_ALRH, ZERO_HALF}, '{OFF_ALRL, ZERO_HALF},
    '{OFF_DIVH, DIVH_RST}, '{OFF_CNTH, CNT_RST},
    '{OFF_CNTL, CNT_RST}, '{8'h28, ZERO_HALF}};
  rtcpc_prow_t prow [3] = '{
    '{16'h0001, 8'h02}, '{16'h0004, 8'h05}, '{16'h001f, 8'h20}};

  rtcpc_core u_rtcpc_core (.clk(clk), .rst(rst), .bus_req(bus_req),
    .prdata_reg(prdata_reg), .pready_reg(pready_reg),
    .pslverr_reg(pslverr_reg), .config_mode_bit(config_mode_bit),
    .write_idle_flag(write_idle_flag), .time_base_tick(time_base_tick),
    .alarm_flag(alarm_flag), .alarm_irq(alarm_irq),
    .overflow_flag(overflow_flag));
  rtcpc_host u_rtcpc_host (.clk(clk), .prdata_reg(prdata_reg),
    .pready_reg(pready_reg), .write_idle_flag(write_idle_flag),
    .bus_req(bus_req), .config_mode_bit(config_mode_bit));

  task automatic chk16(input string nm, input logic [15:0] e,
      input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk1(input string nm, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic chkn(input string nm, input int e, input int g);
    cmp_count++;
    if (g != e) begin
      miscompares++;
      $display("[FAIL] %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  task automatic summarize();
    $display("compares %0d miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    u_rtcpc_host.xfer(1'b0, a, 16'h0000, d);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] x;
    u_rtcpc_host.xfer(1'b1, a, d, x);
  endtask
  // Count edges up to the next event of the chosen kind
  task automatic wait_ev(input int k, output int c);
    c = 0;
    do begin
      @(posedge clk);
      c++;
    end while (c < 300 && (k == 0 ? time_base_tick : k == 1 ?
        alarm_flag : overflow_flag) !== 1'b1);
  endtask
  task automatic set_cnt(input logic [15:0] h, input logic [15:0] l);
    u_rtcpc_host.cfg_enter();
    wr(OFF_CNTH, h);
    wr(OFF_CNTL, l);
    u_rtcpc_host.cfg_leave(busy);
  endtask

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      summarize();
    end
  end

  initial begin
    miscompares = 0;
    cmp_count = 0;
    cycles = 0;
    rst = 1'b1;
    repeat (16) @(posedge clk);
    #1 rst = 1'b0;
    rd(OFF_DIVL, q);
    chk1("divl_rst", 1'b1, q <= 16'h8000 && q >= 16'h7fe0);
    foreach (rrow[i]) begin
      rd(rrow[i].a, q);
      chk16("rst_read", rrow[i].e, q);
    end
    foreach (prow[i]) begin
      u_rtcpc_host.cfg_enter();
      wr(OFF_PRLH, 16'h0000);
      wr(OFF_PRLL, prow[i].prll);
      u_rtcpc_host.cfg_leave(busy);
      chk1("commit_len", 1'b1, busy >= 3);
      wait_ev(0, n);
      wait_ev(0, n);
      chkn("period", int'(prow[i].per), n);
    end
    u_rtcpc_host.cfg_enter();
    wr(OFF_CNTH, 16'h1234);
    wr(OFF_CNTL, 16'h5678);
    rd(OFF_CNTH, q);
    chk16("cnth_deferred", 16'h0000, q);
    u_rtcpc_host.cfg_leave(busy);
    rd(OFF_CNTH, q);
    chk16("cnth", 16'h1234, q);
    rd(OFF_CNTL, q);
    chk16("cntl", 16'h5678, q);
    set_cnt(16'h0001, 16'hffff);
    wait_ev(0, n);
    rd(OFF_CNTH, q);
    chk16("carry_h", 16'h0002, q);
    rd(OFF_CNTL, q);
    chk16("carry_l", 16'h0000, q);
    wr(OFF_CNTL, 16'h00aa);
    rd(OFF_CNTL, q);
    chk16("no_cfg_write", 16'h0000, q);
    chk1("no_cfg_err", 1'b0, pslverr_reg);
    u_rtcpc_host.cfg_enter();
    wr(OFF_ALRH, 16'h0000);
    wr(OFF_ALRL, 16'h0003);
    wr(OFF_CNTH, 16'h0000);
    wr(OFF_CNTL, 16'h0000);
    u_rtcpc_host.cfg_leave(busy);
    wait_ev(1, n);
    chk1("alarm_flag", 1'b1, alarm_flag);
    chk1("alarm_irq", 1'b1, alarm_irq);
    rd(OFF_CNTL, q);
    chk16("alarm_cnt", 16'h0004, q);
    set_cnt(16'hffff, 16'hffff);
    wait_ev(2, n);
    chk1("overflow", 1'b1, overflow_flag);
    rd(OFF_CNTH, q);
    chk16("wrap_h", 16'h0000, q);
    rd(OFF_CNTL, q);
    chk16("wrap_l", 16'h0000, q);
    u_rtcpc_host.cfg_enter();
    wr(OFF_PRLH, 16'hfff1);
    wr(OFF_PRLL, 16'h8000);
    u_rtcpc_host.cfg_leave(busy);
    rd(OFF_DIVH, q);
    chk16("divh", 16'h0001, q);
    rd(OFF_DIVL, q);
    chk1("divl_reload", 1'b1, q <= 16'h8000 && q >= 16'h7fe0);
    rd(OFF_DIVL, q2);
    chk16("divl_live", q - 16'h0003, q2);
    u_rtcpc_host.cfg_enter();
    wr(OFF_CNTL, 16'h0011);
    u_rtcpc_host.cfg_set(1'b0);
    u_rtcpc_host.cfg_set(1'b1);
    wr(OFF_CNTL, 16'h0022);
    u_rtcpc_host.cfg_leave(busy);
    rd(OFF_CNTL, q);
    chk16("busy_write", 16'h0011, q);
    summarize();
  end
endmodule // test_rtc_prescaler_counter_alarm
